// ===== design/fieldbus_slave_pkg.sv
// shared constants and carrier types for the fieldbus slave command decoder
package fieldbus_slave_pkg;

  // node address selection
  localparam logic [7:0] STORED_ADDR_SELECT = 8'h7E;
  localparam logic [6:0] STORED_ADDR_DEFAULT = 7'h7E;
  localparam logic [6:0] MAX_SWITCH_ADDR = 7'h7D;

  // cyclic output byte layout
  localparam int OUT_BYTES = 6;
  localparam int TRIGGER_BYTE = 1;
  localparam int TEACH_BYTE = 3;
  localparam int PROFILE_BYTE = 5;
  localparam int REQUEST_BIT = 0;
  localparam int PROFILE_MSB = 5;
  localparam logic [5:0] PROFILE_MIN = 6'h01;
  localparam logic [5:0] PROFILE_MAX = 6'h20;
  localparam logic [5:0] PROFILE_RESET = 6'h00;

  // switch sampling after reset release
  localparam int SAMPLE_DELAY_NS = 20;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int SAMPLE_DELAY_CYCLES = (SAMPLE_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // one cyclic output frame from the bus master
  typedef struct packed {
    logic valid;
    logic [OUT_BYTES*8-1:0] data;
  } out_frame_t;

  // set-address service request from the bus master
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
  } set_addr_t;

  // commands toward the sensor side
  typedef struct packed {
    logic capture;
    logic learn;
    logic [5:0] profile;
    logic profile_valid;
  } sensor_cmd_t;

endpackage

// ===== design/rising_request_detect.sv
// rising-edge detector for one request bit of a received output byte
`timescale 1ns/1ps
`default_nettype none
module rising_request_detect (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // sampled bit
  input wire logic load,
  input wire logic bit_in,
  input wire logic enable,
  // result
  output logic pulse
);

  typedef struct packed {
    logic last;
    logic pulse;
  } state_t;

  state_t state;
  state_t next_state;

  always_comb begin
    next_state = state;
    next_state.pulse = 1'b0;
    if (load) begin
      // new byte compared with previous one
      next_state.pulse = enable & bit_in & ~state.last;
      next_state.last = bit_in;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pulse = state.pulse;

endmodule
`default_nettype wire

// ===== design/fieldbus_slave_command_decoder.sv
// node address selection and cyclic output byte decoding for a fieldbus slave
`timescale 1ns/1ps
`default_nettype none
module fieldbus_slave_command_decoder #(
  parameter logic [6:0] STORED_DEFAULT = fieldbus_slave_pkg::STORED_ADDR_DEFAULT
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // rotary address switches
  input wire logic [3:0] address_upper_digit_switch,
  input wire logic [3:0] address_lower_digit_switch,
  // nonvolatile stored address, loaded at power-up
  input wire logic [6:0] stored_addr_in,
  input wire logic stored_addr_in_valid,
  // bus master services
  input wire fieldbus_slave_pkg::set_addr_t set_addr,
  input wire fieldbus_slave_pkg::out_frame_t out_frame,
  // address state
  output logic [6:0] node_addr,
  output logic addr_ready,
  output logic addr_from_store,
  output logic exchange_enabled,
  output logic set_addr_accepted,
  output logic set_addr_rejected,
  output logic [6:0] store_write_addr,
  output logic store_write,
  // sensor commands
  output fieldbus_slave_pkg::sensor_cmd_t sensor_cmd
);

  // =====================================================
  // state
  typedef struct packed {
    logic [1:0] wait_count;
    logic sampled;
    logic from_store;
    logic [6:0] addr;
    logic accepted;
    logic rejected;
    logic [6:0] write_addr;
    logic write;
    logic [5:0] profile;
    logic profile_valid;
  } state_t;

  state_t state;
  state_t next_state;
  logic [7:0] switch_value;
  logic sample_now;
  logic store_selected;
  logic [6:0] power_up_addr;
  logic set_addr_taken;
  logic set_addr_allowed;
  logic exchange;
  logic frame_accepted;
  logic trigger_bit;
  logic teach_bit;
  logic [5:0] frame_profile;
  logic capture_pulse;
  logic learn_pulse;

  // =====================================================
  // decoding helpers
  // byte n of the cyclic frame sits at bits 8n+7..8n
  function automatic logic [7:0] frame_byte(input logic [47:0] data, input int idx);
    frame_byte = data[idx*8 +: 8];
  endfunction

  // request bit of one output byte; only its rise asks for an action
  function automatic logic request_bit(input logic [47:0] data, input int idx);
    logic [7:0] byte_value;
    byte_value = frame_byte(data, idx);
    request_bit = byte_value[fieldbus_slave_pkg::REQUEST_BIT];
  endfunction

  function automatic logic [5:0] profile_field(input logic [47:0] data);
    logic [7:0] byte_value;
    byte_value = frame_byte(data, fieldbus_slave_pkg::PROFILE_BYTE);
    profile_field = byte_value[fieldbus_slave_pkg::PROFILE_MSB:0];
  endfunction

  // profile numbers 1..32 are defined, 0 and anything above 32 are not
  function automatic logic profile_defined(input logic [5:0] value);
    profile_defined = (value >= fieldbus_slave_pkg::PROFILE_MIN)
      && (value <= fieldbus_slave_pkg::PROFILE_MAX);
  endfunction

  // values above 125 other than 7E fall back to the highest legal address
  function automatic logic [6:0] switch_address(input logic [7:0] value);
    if (value[7] || (value[6:0] > fieldbus_slave_pkg::MAX_SWITCH_ADDR)) begin
      switch_address = fieldbus_slave_pkg::MAX_SWITCH_ADDR;
    end else begin
      switch_address = value[6:0];
    end
  endfunction

  // an empty store leaves the built-in default in force
  function automatic logic [6:0] stored_address(input logic usable, input logic [6:0] value);
    if (usable) begin
      stored_address = value;
    end else begin
      stored_address = STORED_DEFAULT;
    end
  endfunction

  // =====================================================
  // address sources
  assign switch_value = {address_upper_digit_switch, address_lower_digit_switch};
  assign sample_now = (state.wait_count == 2'(fieldbus_slave_pkg::SAMPLE_DELAY_CYCLES));
  assign store_selected = (switch_value == fieldbus_slave_pkg::STORED_ADDR_SELECT);
  assign power_up_addr = store_selected
    ? stored_address(stored_addr_in_valid, stored_addr_in)
    : switch_address(switch_value);
  assign set_addr_taken = state.sampled && set_addr.valid;
  // only a stored address may be replaced, and only by a legal one
  assign set_addr_allowed = state.from_store
    && (set_addr.addr <= fieldbus_slave_pkg::MAX_SWITCH_ADDR);
  assign exchange = state.sampled
    && (state.addr != fieldbus_slave_pkg::STORED_ADDR_DEFAULT);

  // =====================================================
  // cyclic frame fields, bytes 0, 2 and 4 are never read
  assign frame_accepted = exchange && out_frame.valid;
  assign trigger_bit = request_bit(out_frame.data, fieldbus_slave_pkg::TRIGGER_BYTE);
  assign teach_bit = request_bit(out_frame.data, fieldbus_slave_pkg::TEACH_BYTE);
  assign frame_profile = profile_field(out_frame.data);

  // =====================================================
  // address selection and profile decode
  always_comb begin
    next_state = state;
    // service answers stand for one cycle
    next_state.accepted = 1'b0;
    next_state.rejected = 1'b0;
    next_state.write = 1'b0;
    if (!state.sampled) begin
      if (!sample_now) begin
        next_state.wait_count = state.wait_count + 2'h1;
      end else begin
        // once only, held until the next power cycle
        next_state.sampled = 1'b1;
        next_state.from_store = store_selected;
        next_state.addr = power_up_addr;
      end
    end else if (set_addr_taken) begin
      if (set_addr_allowed) begin
        next_state.addr = set_addr.addr;
        next_state.write_addr = set_addr.addr;
        next_state.write = 1'b1;
        next_state.accepted = 1'b1;
      end else begin
        next_state.rejected = 1'b1;
      end
    end
    if (frame_accepted) begin
      next_state.profile = frame_profile;
      next_state.profile_valid = profile_defined(frame_profile);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // =====================================================
  // request edge detection
  rising_request_detect trigger_detect (
    .clock(clock),
    .rstn(rstn),
    .load(out_frame.valid),
    .bit_in(trigger_bit),
    .enable(exchange),
    .pulse(capture_pulse)
  );

  rising_request_detect teach_detect (
    .clock(clock),
    .rstn(rstn),
    .load(out_frame.valid),
    .bit_in(teach_bit),
    .enable(exchange),
    .pulse(learn_pulse)
  );

  // =====================================================
  // outputs
  assign node_addr = state.addr;
  assign addr_ready = state.sampled;
  assign addr_from_store = state.from_store;
  assign exchange_enabled = exchange;
  assign set_addr_accepted = state.accepted;
  assign set_addr_rejected = state.rejected;
  assign store_write_addr = state.write_addr;
  assign store_write = state.write;
  // sensor commands come straight from flip-flops
  assign sensor_cmd.capture = capture_pulse;
  assign sensor_cmd.learn = learn_pulse;
  assign sensor_cmd.profile = state.profile;
  assign sensor_cmd.profile_valid = state.profile_valid;

endmodule
`default_nettype wire

// ===== sim/decoder_props.sv
// assertion checker for the fieldbus slave command decoder
`timescale 1ns/1ps
`default_nettype none
module decoder_props (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // master side
  input wire fieldbus_slave_pkg::set_addr_t set_addr,
  input wire fieldbus_slave_pkg::out_frame_t out_frame,
  // results
  input wire logic [6:0] node_addr,
  input wire logic addr_ready,
  input wire logic addr_from_store,
  input wire logic exchange_enabled,
  input wire logic set_addr_accepted,
  input wire logic set_addr_rejected,
  input wire fieldbus_slave_pkg::sensor_cmd_t sensor_cmd
);
  logic pt;
  logic pl;
  wire logic t_rise = out_frame.valid && out_frame.data[8] && !pt && exchange_enabled;
  wire logic l_rise = out_frame.valid && out_frame.data[24] && !pl && exchange_enabled;
  wire logic sa_ok = set_addr.valid && addr_ready;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // request bits of the last frame
  always_ff @(posedge clock) begin
    if (!rstn) {pt, pl} <= 2'h0;
    else if (out_frame.valid) {pt, pl} <= {out_frame.data[8], out_frame.data[24]};
  end
  sequence s_trig; t_rise; endsequence
  sequence s_learn; l_rise; endsequence
  AST_CAPTURE: assert property (s_trig |=> sensor_cmd.capture)
    else $error("capture");
  AST_ONE_CAPTURE: assert property (sensor_cmd.capture |-> $past(t_rise))
    else $error("extra capture");
  AST_LEARN: assert property (s_learn |=> sensor_cmd.learn)
    else $error("learn");
  AST_NO_126: assert property (exchange_enabled |-> node_addr != 7'h7E)
    else $error("exchange at 126");
  AST_LOCK: assert property (sa_ok && !addr_from_store |=> !set_addr_accepted)
    else $error("switch address changed");
  AST_STORE: assert property (sa_ok && addr_from_store && set_addr.addr <= 7'h7D
    |=> set_addr_accepted && node_addr == $past(set_addr.addr)) else $error("store");
  AST_HOLD: assert property ($past(addr_ready) && !set_addr_accepted |-> $stable(node_addr))
    else $error("address moved");
  AST_PROFILE: assert property (out_frame.valid && exchange_enabled
    |=> sensor_cmd.profile == $past(out_frame.data[45:40])) else $error("profile");
  AST_REJECT: assert property (sa_ok && (!addr_from_store || set_addr.addr > 7'h7D)
    |=> set_addr_rejected && !set_addr_accepted) else $error("refusal");
  AST_QUIET_126: assert property (!exchange_enabled
    |=> !sensor_cmd.capture && !sensor_cmd.learn) else $error("request at 126");
endmodule
bind fieldbus_slave_command_decoder decoder_props props (.clock, .rstn, .set_addr, .out_frame,
  .node_addr, .addr_ready, .addr_from_store, .exchange_enabled, .set_addr_accepted,
  .set_addr_rejected, .sensor_cmd);
`default_nettype wire

// ===== sim/plc_master_model.sv
// bus master model driving frames and set-address services
`timescale 1ns/1ps
`default_nettype none
module plc_master_model (
  // clock
  input wire logic clock,
  // services
  output fieldbus_slave_pkg::out_frame_t out_frame,
  output fieldbus_slave_pkg::set_addr_t set_addr
);
  initial out_frame = '0;
  initial set_addr = '0;
  // one valid frame for a single clock, then valid drops with the data inverted
  task automatic send_frame(input logic [47:0] d);
    out_frame = {1'b1, d};
    @(posedge clock);
    #1;
    out_frame = {1'b0, ~d};
  endtask
  // readdressing only over the bus
  task automatic set_address(input logic [6:0] a);
    set_addr = {1'b1, a};
    @(posedge clock);
    #1;
    set_addr = {1'b0, ~a};
  endtask
endmodule
`default_nettype wire

// ===== sim/fieldbus_slave_command_decoder_tb.sv
// self-checking bench for the fieldbus slave command decoder
`timescale 1ns/1ps
`default_nettype none
module fieldbus_slave_command_decoder_tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] sw_hi = 4'h0;
  logic [3:0] sw_lo = 4'h0;
  fieldbus_slave_pkg::out_frame_t frame;
  fieldbus_slave_pkg::set_addr_t sa;
  fieldbus_slave_pkg::sensor_cmd_t cmd;
  logic [6:0] node;
  logic [6:0] wr_addr;
  logic rdy, from_st, exch, acc, rej, wr, pt, pl, ex;
  logic [5:0] prof;
  logic [6:0] st_addr = 7'h15;
  logic st_valid = 1'b0;
  logic [31:0] seed = 32'h00008B85;
  int num_errors = 0;
  int num_checks = 0;
  always #5 clock = ~clock;
  plc_master_model master (.clock, .out_frame(frame), .set_addr(sa));
  fieldbus_slave_command_decoder uut (.clock, .rstn, .address_upper_digit_switch(sw_hi),
    .address_lower_digit_switch(sw_lo), .stored_addr_in(st_addr), .stored_addr_in_valid(st_valid),
    .set_addr(sa), .out_frame(frame), .node_addr(node), .addr_ready(rdy),
    .addr_from_store(from_st), .exchange_enabled(exch), .set_addr_accepted(acc),
    .set_addr_rejected(rej), .store_write_addr(wr_addr), .store_write(wr), .sensor_cmd(cmd));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] rise(input logic prev, input logic now);
    return {7'h0, ex & now & ~prev};
  endfunction
  function automatic logic [7:0] exp_prof(input logic [5:0] p);
    return {1'h0, p, p >= 6'h01 && p <= 6'h20};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic boot(input logic [3:0] h, input logic [3:0] l, input logic s);
    rstn = 1'b0;
    {sw_hi, sw_lo, st_valid, pt, pl, prof} = {h, l, s, 8'h00};
    repeat (8) @(posedge clock);
    #1 rstn = 1'b1;
    for (int n = 0; rdy !== 1'b1; n++) begin
      if (n > 9) check(8'h00, 8'h01);
      if (n > 9) conclude();
      @(posedge clock);
      #1;
    end
  endtask
  task automatic send(input logic [47:0] d);
    master.send_frame(d);
    if (ex) prof = d[45:40];
    check({7'h0, cmd.capture}, rise(pt, d[8]));
    check({7'h0, cmd.learn}, rise(pl, d[24]));
    check({1'h0, cmd.profile, cmd.profile_valid}, exp_prof(prof));
    {pt, pl} = {d[8], d[24]};
    @(posedge clock);
    #1;
    check({6'h0, cmd.capture, cmd.learn}, 8'h00);
  endtask
  task automatic setad(input logic [6:0] a, input logic ok, input logic [6:0] n);
    master.set_address(a);
    check({5'h0, acc, rej, wr}, {5'h0, ok, ~ok, ok});
    check({1'h0, node}, {1'h0, n});
    if (ok) check({1'h0, wr_addr}, {1'h0, a});
    @(posedge clock);
    #1;
    check({5'h0, acc, rej, wr}, 8'h00);
  endtask
  initial begin
    logic [31:0] v, w;
    static logic [47:0] corner [7] = '{48'h000001000000, 48'h000001000100, 48'h000001000100,
      48'h0, 48'h000000000100, 48'h200000000000, 48'h21FF00FF00FF};
    boot(4'h1, 4'hA, 1'b1);
    ex = 1'b1;
    check({exch, node}, 8'h9A);
    check({7'h0, from_st}, 8'h00);
    {sw_hi, sw_lo} = 8'h7E;
    repeat (3) @(posedge clock);
    #1;
    setad(7'h22, 1'b0, 7'h1A);
    $display("test switch address done");
    foreach (corner[i]) send(corner[i]);
    for (int i = 0; i < 60; i++) begin
      v = rnd();
      w = rnd();
      send({v, w[15:0]});
    end
    $display("test frames done");
    boot(4'h7, 4'hE, 1'b0);
    ex = 1'b0;
    check({from_st, node}, 8'hFE);
    check({7'h0, exch}, 8'h00);
    send(48'h000001000100);
    setad(7'h7E, 1'b0, 7'h7E);
    setad(7'h30, 1'b1, 7'h30);
    ex = 1'b1;
    send(48'h0);
    send(48'h000000000100);
    $display("test stored address done");
    boot(4'h7, 4'hE, 1'b1);
    check({from_st, node}, 8'h95);
    check({7'h0, exch}, 8'h01);
    send(48'h000000000100);
    setad(7'h05, 1'b1, 7'h05);
    $display("test saved address done");
    conclude();
  end
endmodule
`default_nettype wire
